// File: rtl/wdw_watchdog.sv
`timescale 1ns/1ns
module wdw_watchdog
    import wdw_pkg::*;
#(
    parameter int TICK_CYC = wdw_pkg::WDW_TICK_CYC
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic arst_n,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // core and system
    input wire logic [7:0] boot_watchdog_fuse,
    input wire logic boot_done,
    input wire logic timed_unlock_protection,
    input wire logic debug_mode,
    input wire logic watchdog_restart_instr,
    // outputs
    output logic system_reset,
    output logic watchdog_enabled
);
    import wdw_pkg::*;

    function automatic logic [23:0] code_ticks(input logic [3:0] code);
        if (code == WDW_CODE_OFF || code > WDW_CODE_MAX) begin
            code_ticks = 24'h00_0000;
        end else begin
            code_ticks = 24'(WDW_BASE_TICKS) << (code - 4'h1);
        end
    endfunction

    ////////////////////////////////////////////////////////////////////
    // pin synchronisers
    logic boot_done_s;
    logic debug_s;
    logic restart_s;
    wdw_sync2 u_sync_boot (
        .ref_clk(ref_clk),
        .arst_n(arst_n),
        .din(boot_done),
        .dout(boot_done_s)
    );
    wdw_sync2 u_sync_dbg (
        .ref_clk(ref_clk),
        .arst_n(arst_n),
        .din(debug_mode),
        .dout(debug_s)
    );
    wdw_sync2 u_sync_wdr (
        .ref_clk(ref_clk),
        .arst_n(arst_n),
        .din(watchdog_restart_instr),
        .dout(restart_s)
    );

    logic tick;
    wdw_tick #(
        .CYCLES(TICK_CYC)
    ) u_tick (
        .ref_clk(ref_clk),
        .arst_n(arst_n),
        .tick(tick)
    );

    ////////////////////////////////////////////////////////////////////
    // registers
    logic [7:0] watchdog_control;
    logic lock;
    logic clock_crossing_pending;
    logic [7:0] active_ctrl;
    logic [1:0] sync_cnt;
    logic boot_seen;
    logic boot_prev;
    logic wr_ctrl;
    logic wr_stat;
    assign wr_ctrl = reg_wr && reg_addr == WDW_CTRL_ADDR;
    assign wr_stat = reg_wr && reg_addr == WDW_STAT_ADDR;

    // fuse loaded once at boot completion
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            boot_prev <= 1'b0;
        end else begin
            boot_prev <= boot_done_s;
        end
    end
    assign boot_seen = boot_done_s && !boot_prev;

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            watchdog_control <= 8'h00;
        end else if (boot_seen) begin
            watchdog_control <= boot_watchdog_fuse;
        end else if (wr_ctrl && timed_unlock_protection && !lock) begin
            watchdog_control <= reg_wdata;
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            lock <= WDW_STAT_RESET[WDW_LOCK_BIT];
        end else if (boot_seen &&
                     boot_watchdog_fuse[3:0] != WDW_CODE_OFF) begin
            lock <= 1'b1;
        end else if (wr_stat && timed_unlock_protection) begin
            if (reg_wdata[WDW_LOCK_BIT]) begin
                lock <= 1'b1;
            end else if (debug_s) begin
                lock <= 1'b0;
            end
        end
    end

    // crossing: value taken after WDW_SYNC_TICKS watchdog ticks
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            clock_crossing_pending <= 1'b0;
            sync_cnt <= 2'h0;
        end else if ((wr_ctrl && timed_unlock_protection && !lock)
                     || boot_seen) begin
            clock_crossing_pending <= 1'b1;
            sync_cnt <= 2'h0;
        end else if (clock_crossing_pending && tick) begin
            if (sync_cnt == 2'(WDW_SYNC_TICKS - 1)) begin
                clock_crossing_pending <= 1'b0;
            end
            sync_cnt <= sync_cnt + 2'h1;
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            active_ctrl <= 8'h00;
        end else if (clock_crossing_pending && tick &&
                     sync_cnt == 2'(WDW_SYNC_TICKS - 1)) begin
            active_ctrl <= watchdog_control;
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                WDW_CTRL_ADDR: reg_rdata <= watchdog_control;
                WDW_STAT_ADDR: begin
                    reg_rdata <= 8'h00;
                    reg_rdata[WDW_LOCK_BIT] <= lock;
                    reg_rdata[WDW_BUSY_BIT] <= clock_crossing_pending;
                end
                default: reg_rdata <= 8'h00;
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // timeout engine
    wdw_state_t state;
    logic [23:0] count;
    logic restart_prev;
    logic restart_ev;
    logic [3:0] per_code;
    logic [3:0] win_code;
    assign per_code = active_ctrl[WDW_PER_LSB +: 4];
    assign win_code = active_ctrl[WDW_WIN_LSB +: 4];

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            restart_prev <= 1'b0;
        end else begin
            restart_prev <= restart_s;
        end
    end
    assign restart_ev = restart_s && !restart_prev;

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            state <= WDW_OFF;
            count <= 24'h00_0000;
            system_reset <= 1'b0;
        end else if (code_ticks(per_code) == 24'h00_0000 || debug_s) begin
            state <= WDW_OFF;
            count <= 24'h00_0000;
            system_reset <= 1'b0;
        end else begin
            system_reset <= 1'b0;
            case (state)
                WDW_OFF: begin
                    count <= 24'h00_0000;
                    state <= win_code != WDW_CODE_OFF ? WDW_ARMWAIT
                                                      : WDW_OPEN;
                end
                WDW_ARMWAIT, WDW_OPEN: begin
                    if (restart_ev) begin
                        count <= 24'h00_0000;
                        state <= win_code != WDW_CODE_OFF ? WDW_CLOSED
                                                          : WDW_OPEN;
                    end else if (tick) begin
                        if (count + 24'h00_0001 >= code_ticks(per_code)) begin
                            system_reset <= 1'b1;
                            count <= 24'h00_0000;
                        end else begin
                            count <= count + 24'h00_0001;
                        end
                    end
                end
                WDW_CLOSED: begin
                    if (restart_ev) begin
                        system_reset <= 1'b1;
                        count <= 24'h00_0000;
                    end else if (win_code == WDW_CODE_OFF) begin
                        state <= WDW_OPEN;
                        count <= 24'h00_0000;
                    end else if (tick) begin
                        if (count + 24'h00_0001 >= code_ticks(win_code)) begin
                            state <= WDW_OPEN;
                            count <= 24'h00_0000;
                        end else begin
                            count <= count + 24'h00_0001;
                        end
                    end
                end
                default: state <= WDW_OFF;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            watchdog_enabled <= 1'b0;
        end else begin
            watchdog_enabled <= per_code != WDW_CODE_OFF;
        end
    end
endmodule

// File: rtl/wdw_pkg.sv
// Summary of operation
// - timeout codes 0x1..0xb enable watchdog and double from 8 ms; 0xc..0xf set only watchdog_enabled
// - nonzero closed-window code enables window mode, 8 ms to 8.192 s for 0x1..0xb; 0xc..0xf end the closed window at the next tick
// - in window mode the timeout code sets the open-window length
// - control: closed-window field bits 7:4, timeout field bits 3:0, rw
// - lock bit set makes both control fields read-only, writes dropped
// - software may only set lock; clearing only in debug mode
// - nonzero timeout code after boot sets lock automatically
// - a control write accepted while unlocked and inside the unlock window sets crossing-pending flag in status bit 0
// - hardware clears crossing-pending flag once transfer completes
// - lock write accepted only inside the timed unlock window
// - crossing-pending flag is read-only, outside unlock protection
// - status at offset 0x01, resets to 0x00
// - no restart before timeout expiry issues a system reset
// - each restart clears the count and starts a fresh period
// - restart in the closed period resets the system immediately
// - control reset value comes from the boot watchdog fuse
package wdw_pkg;
    localparam logic [7:0] WDW_CTRL_ADDR = 8'h00;
    localparam logic [7:0] WDW_STAT_ADDR = 8'h01;
    localparam int WDW_WIN_LSB = 4;
    localparam int WDW_PER_LSB = 0;
    localparam int WDW_LOCK_BIT = 7;
    localparam int WDW_BUSY_BIT = 0;
    localparam logic [7:0] WDW_STAT_RESET = 8'h00;
    localparam logic [3:0] WDW_CODE_OFF = 4'h0;
    localparam logic [3:0] WDW_CODE_MAX = 4'hb;
    // watchdog tick: about 1 kHz from the system clock
    localparam int WDW_CLK_HZ = 10_000_000;
    localparam int WDW_TICK_HZ = 1_000;
    localparam int WDW_TICK_CYC = WDW_CLK_HZ / WDW_TICK_HZ;
    // ticks of shortest period (code 0x1 = 8 ticks)
    localparam int WDW_BASE_TICKS = 8;
    // crossing delay in watchdog ticks
    localparam int WDW_SYNC_TICKS = 2;
    typedef enum logic [1:0] {
        WDW_OFF = 2'b00,
        WDW_OPEN = 2'b01,
        WDW_CLOSED = 2'b10,
        WDW_ARMWAIT = 2'b11
    } wdw_state_t;
endpackage

// File: rtl/wdw_tick.sv
`timescale 1ns/1ns
module wdw_tick #(
    parameter int CYCLES = 10000
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic arst_n,
    // enable out
    output logic tick
);
    logic [31:0] cnt;

    initial begin
        if (CYCLES < 1) begin
            $error("tick divider must be at least one cycle");
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt <= 32'h0000_0000;
            tick <= 1'b0;
        end else if (cnt == 32'(CYCLES - 1)) begin
            cnt <= 32'h0000_0000;
            tick <= 1'b1;
        end else begin
            cnt <= cnt + 32'h0000_0001;
            tick <= 1'b0;
        end
    end
endmodule

// File: rtl/wdw_sync2.sv
`timescale 1ns/1ns
module wdw_sync2 (
    // clock and reset
    input wire logic ref_clk,
    input wire logic arst_n,
    // level in and out
    input wire logic din,
    output logic dout
);
    logic meta;

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            meta <= 1'b0;
            dout <= 1'b0;
        end else begin
            meta <= din;
            dout <= meta;
        end
    end
endmodule

// File: test/wdw_checker.sv
`timescale 1ns/1ns
module wdw_chk #(
    parameter int TICK_CYC = 10
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic arst_n,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    // system
    input wire logic timed_unlock_protection,
    input wire logic debug_mode,
    input wire logic system_reset,
    input wire logic watchdog_enabled
);
    import wdw_pkg::*;
    default clocking @(posedge ref_clk);
    endclocking
    default disable iff (!arst_n);
    logic [2:0] dbg_q;
    logic rd_q;
    logic lock_seen;
    wire rd_ctl = reg_rd && reg_addr == WDW_CTRL_ADDR;
    wire rd_st = reg_rd && reg_addr == WDW_STAT_ADDR;
    ////////////////////////////////////////
    // quiet debug time and lock seen set
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            dbg_q <= 3'h0;
            rd_q <= 1'b0;
        end else begin
            dbg_q <= debug_mode ? 3'h0 : dbg_q + {2'h0, dbg_q != 3'h7};
            rd_q <= rd_st;
        end
    end
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            lock_seen <= 1'b0;
        end else if (debug_mode) begin
            lock_seen <= 1'b0;
        end else if (rd_q && dbg_q == 3'h7 && reg_rdata[WDW_LOCK_BIT]) begin
            lock_seen <= 1'b1;
        end
    end
    ////////////////////////////////////////
    sequence s_ctl_wr;
        reg_wr && reg_addr == WDW_CTRL_ADDR && timed_unlock_protection;
    endsequence
    sequence s_off_seen;
        rd_ctl ##1 (reg_rdata[3:0] == WDW_CODE_OFF) ##1 rd_st
            ##1 !reg_rdata[WDW_BUSY_BIT];
    endsequence
    AST_RD_IDLE: assert property (!reg_rd |=> reg_rdata == 8'h00)
        else $error("read data not idle");
    AST_UNMAPPED: assert property (
        reg_rd && reg_addr > WDW_STAT_ADDR |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    AST_STAT_RSV: assert property (rd_st |=> reg_rdata[6:1] == 6'h00)
        else $error("status spare bits set");
    AST_RST_PULSE: assert property (system_reset |=> !system_reset)
        else $error("system reset too long");
    AST_RST_CAUSE: assert property (
        system_reset |-> $past(watchdog_enabled))
        else $error("reset while watchdog off");
    AST_WR_PEND: assert property (
        s_ctl_wr ##2 rd_st |=> reg_rdata[WDW_LOCK_BIT] || reg_rdata[0])
        else $error("no pending after control write");
    AST_LOCK_STICKY: assert property (
        rd_st && lock_seen && !debug_mode |=> reg_rdata[WDW_LOCK_BIT])
        else $error("lock cleared outside debug");
    AST_ENA_OFF: assert property (s_off_seen |-> !watchdog_enabled)
        else $error("enabled with timeout off");
endmodule
bind wdw_watchdog wdw_chk #(.TICK_CYC(TICK_CYC)) wdw_chk_i (
    .ref_clk, .arst_n, .reg_addr, .reg_wr, .reg_rd, .reg_rdata,
    .timed_unlock_protection, .debug_mode, .system_reset,
    .watchdog_enabled
);

// File: test/tb.sv
`timescale 1ns/1ns
module tb;
    import wdw_pkg::*;
    logic ref_clk = 1'b0;
    logic arst_n = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic [7:0] fuse = 8'h00;
    logic boot_done = 1'b0;
    logic unlock = 1'b0;
    logic debug_mode = 1'b0;
    logic restart = 1'b0;
    logic system_reset;
    logic watchdog_enabled;
    int error_cnt = 0;
    int num_checks = 0;
    int n;
    always #50 ref_clk = ~ref_clk;
    wdw_watchdog #(.TICK_CYC(10)) wdw_watchdog_i (
        .ref_clk, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .boot_watchdog_fuse(fuse), .boot_done,
        .timed_unlock_protection(unlock), .debug_mode,
        .watchdog_restart_instr(restart), .system_reset, .watchdog_enabled
    );
    ////////////////////////////////////////
    task automatic complete_run();
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic chk(string nm, logic [7:0] exp, logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic chkr(string nm, int lo, int hi, int got);
        num_checks++;
        if (got < lo || got > hi) begin
            error_cnt++;
            $display("MISMATCH %s expected %0d..%0d seen %0d", nm, lo, hi, got);
        end
    endtask
    task automatic wr(logic [7:0] a, logic [7:0] d, logic u);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        unlock <= u;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        unlock <= 1'b0;
    endtask
    task automatic rd(logic [7:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask
    task automatic rdc(logic [7:0] a, logic [7:0] exp, string nm);
        logic [7:0] d;
        rd(a, d);
        chk(nm, exp, d);
    endtask
    task automatic wait_pend();
        logic [7:0] d;
        for (int i = 0; i < 40; i++) begin
            rd(WDW_STAT_ADDR, d);
            if (d[WDW_BUSY_BIT] === 1'b0) return;
        end
        chk("pending clear", 8'h00, d);
        complete_run();
    endtask
    task automatic kick();
        @(posedge ref_clk);
        restart <= 1'b1;
    endtask
    // cycles until a reset pulse, max if none
    task automatic wait_rst(int max, output int cnt);
        for (cnt = 0; cnt < max; cnt++) begin
            @(posedge ref_clk);
            restart <= 1'b0;
            #1;
            if (system_reset === 1'b1) return;
        end
    endtask
    ////////////////////////////////////////
    initial begin
        repeat (16) @(posedge ref_clk);
        arst_n <= 1'b1;
        rdc(WDW_STAT_ADDR, WDW_STAT_RESET, "status reset");
        rdc(8'h05, 8'h00, "unmapped");
        @(posedge ref_clk);
        fuse <= 8'h02;
        boot_done <= 1'b1;
        repeat (4) @(posedge ref_clk);
        wait_pend();
        rdc(WDW_CTRL_ADDR, 8'h02, "fuse control");
        rdc(WDW_STAT_ADDR, 8'h80, "boot lock");
        chk("enabled", 8'h01, {7'h00, watchdog_enabled});
        wr(WDW_CTRL_ADDR, 8'h00, 1'b1);
        wait_pend();
        rdc(WDW_CTRL_ADDR, 8'h02, "locked control");
        for (int k = 0; k < 3; k++) begin
            kick();
            wait_rst(120, n);
            chkr("restart gap", 120, 120, n);
        end
        kick();
        wait_rst(300, n);
        chkr("timeout", 140, 175, n);
        wr(WDW_STAT_ADDR, 8'h01, 1'b1);
        rdc(WDW_STAT_ADDR, 8'h80, "sticky lock");
        @(posedge ref_clk);
        debug_mode <= 1'b1;
        repeat (5) @(posedge ref_clk);
        wr(WDW_STAT_ADDR, 8'h00, 1'b1);
        debug_mode <= 1'b0;
        rdc(WDW_STAT_ADDR, 8'h00, "debug unlock");
        wr(WDW_STAT_ADDR, 8'h80, 1'b0);
        wr(WDW_CTRL_ADDR, 8'h00, 1'b0);
        wait_pend();
        rdc(WDW_CTRL_ADDR, 8'h02, "unprotected ctrl");
        rdc(WDW_STAT_ADDR, 8'h00, "unprotected lock");
        kick();
        wait_rst(2, n);
        wr(WDW_CTRL_ADDR, 8'h21, 1'b1);
        rdc(WDW_STAT_ADDR, 8'h01, "pending");
        wait_pend();
        rdc(WDW_CTRL_ADDR, 8'h21, "fields");
        kick();
        wait_rst(190, n);
        chkr("closed and open", 190, 190, n);
        kick();
        wait_rst(100, n);
        chkr("closed again", 100, 100, n);
        kick();
        wait_rst(20, n);
        chkr("early restart", 0, 19, n);
        wr(WDW_CTRL_ADDR, 8'h00, 1'b1);
        wait_pend();
        rdc(WDW_CTRL_ADDR, 8'h00, "off");
        rdc(WDW_STAT_ADDR, 8'h00, "idle");
        chk("disabled", 8'h00, {7'h00, watchdog_enabled});
        complete_run();
    end
endmodule
